// ---- include/nand_seq_defs.svh ----
// What this block does
// (R1) Sequential cache read loads next page while cache register stays readable.
// (R2) Cache read commands accepted when die ready, or during an ongoing cache read.
// (R3) After a cache read command the die goes busy with both ready bits clear.
// (R4) After sequential or random cache read, die ready, array busy, output from column 0.
// (R5) During cache output the host may issue random data read to move the column.
// (R6) Sequential cache read past a block end continues in the next logical block.
// (R7) Host never crosses a die boundary with sequential cache read; uses last cache read.
// (R8) Random cache read is 00h, address cycles, 31h; column part is ignored.
// (R9) Random cache read addresses the same die as the preceding page read.
// (R10) Multi-die targets select one die by enhanced status then read mode first.
// (R11) Last cache read copies data register to cache; afterwards both ready bits set.
// (R12) Two-plane read: 00h, address plane 0, 00h, address plane 1, then 30h.
// (R13) Both two-plane addresses share a die, differ in plane, match in column.
// (R14) After two-plane confirm wait for busy end, read plane 0, select plane 1.
// (R15) Two-plane read watched by status needs plane select before any read-out.
// (R16) Host never issues enhanced status during or after a two-plane read.
// (R17) Pages within a block are programmed in strictly ascending order.
// (R18) Plain page program writes one page; host checks program fail when ready.
// (R19) Cache program: busy while copying, then die ready with array busy.
// (R20) During cache program busy only status commands and reset are valid.
// (R21) While a cache program series runs only program-related commands are valid.
// (R22) Two-plane program commands before a program or cache program queue planes; the host refuses 11h during a cache program series.
// (R23) During cache read busy only status commands and reset are valid.
// (R24) Read mode switches the die from status output back to data output.
// (R25) Commands not valid for the current ready state are not issued.
//
// Constants shared by the NAND cache host and its pin-cycle engine.
// Assumes a single NAND die on the pins and one 125 MHz clock.
`ifndef NAND_SEQ_DEFS_SVH
`define NAND_SEQ_DEFS_SVH

`define CLK_NS          8
`define CYC_CEIL(ns)    (((ns) + `CLK_NS - 1) / `CLK_NS)
`define WE_LOW_NS       25
`define WE_HIGH_NS      15
`define RE_LOW_NS       25
`define RE_HIGH_NS      15
`define WB_NS           100
`define SYNC_CYC        3
`define WE_LOW_CYC      `CYC_CEIL(`WE_LOW_NS)
`define WE_HIGH_CYC     `CYC_CEIL(`WE_HIGH_NS)
`define RE_LOW_CYC      (`CYC_CEIL(`RE_LOW_NS) + `SYNC_CYC)
`define RE_HIGH_CYC     `CYC_CEIL(`RE_HIGH_NS)
`define WB_CYC          (`CYC_CEIL(`WB_NS) + `SYNC_CYC)

`define CMD_READ        8'h00
`define CMD_READ_GO     8'h30
`define CMD_CACHE_SEQ   8'h31
`define CMD_CACHE_LAST  8'h3F
`define CMD_COL_OUT     8'h05
`define CMD_PLANE_OUT   8'h06
`define CMD_COL_GO      8'hE0
`define CMD_STATUS      8'h70
`define CMD_STATUS_ENH  8'h78
`define CMD_PROG        8'h80
`define CMD_COL_IN      8'h85
`define CMD_PROG_GO     8'h10
`define CMD_PROG_CACHE  8'h15
`define CMD_PROG_PLANE  8'h11
`define CMD_RESET       8'hFF

`define OP_SEQ_CACHE    5'h00
`define OP_RAND_CACHE   5'h01
`define OP_LAST_CACHE   5'h02
`define OP_TP_READ      5'h03
`define OP_COL_OUT      5'h04
`define OP_PLANE_SEL    5'h05
`define OP_STATUS       5'h06
`define OP_STATUS_ENH   5'h07
`define OP_READ_MODE    5'h08
`define OP_PROG_SETUP   5'h09
`define OP_COL_IN       5'h0A
`define OP_DATA_IN      5'h0B
`define OP_DATA_OUT     5'h0C
`define OP_PROG_GO      5'h0D
`define OP_PROG_CACHE   5'h0E
`define OP_PROG_PLANE   5'h0F
`define OP_RESET        5'h10
`define OP_LAST         5'h10

`define REG_CTRL        8'h00
`define REG_ADDR_LO     8'h04
`define REG_ADDR_HI     8'h08
`define REG_WDATA       8'h0C
`define REG_RDATA       8'h10
`define REG_STATUS      8'h14

`define ST_ARRAY_READY_BIT     5
`define ST_RDY_BIT      6
`define ERR_BIT         2
`define PLANE_BYTE      2
`define PLANE_BIT       6
`define ROW_BITS        17
`define PAGE_BITS       6

`endif

// ---- include/nand_seq_pkg.sv ----
// Types shared by the NAND cache host and its pin-cycle engine.
// Assumes the constants header is compiled alongside.
package nand_seq_pkg;
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_DIN, K_DOUT} step_kind_t;
  typedef struct packed {
    step_kind_t kind;
    logic [7:0] value;
    logic       last;
    logic       wait_busy;
  } step_t;
  typedef enum logic [1:0] {M_IDLE, M_CACHE_READ, M_CACHE_PROG} mode_t;
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} seq_state_t;
  typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} cyc_state_t;
endpackage

// ---- core/nand_bus_cycle.sv ----
// One NAND bus cycle: command, address, data-in or data-out strobe.
// Assumes the caller holds step_i stable in the start cycle only.
`timescale 1ns/1ps
`include "nand_seq_defs.svh"
module nand_bus_cycle (
  // Clock and reset.
  input  wire logic            ref_clk_i,
  input  wire logic            reset_n_i,
  // Request and answer.
  input  wire logic            start_i,
  input  nand_seq_pkg::step_t  step_i,
  output logic                 done_o,
  output logic [7:0]           rdata_o,
  // Pins.
  output logic                 cle_o,
  output logic                 ale_o,
  output logic                 we_n_o,
  output logic                 re_n_o,
  output logic [7:0]           dq_o,
  output logic                 dq_oe_n_o,
  input  wire logic [7:0]      dq_i
);
  import nand_seq_pkg::*;

  cyc_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic       next_done, next_cle, next_ale, next_we_n, next_re_n, next_oe_n;
  logic [7:0] next_dq, next_rdata;
  logic [7:0] dq_s1, dq_s2, dq_s3;

  // The data bus comes from another chip, so it runs through three flip-flops.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
    end else begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // Strobe timing; a read waits for stages two and three to agree before capture.
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_done  = 1'b0;
    next_cle   = cle_o;
    next_ale   = ale_o;
    next_we_n  = we_n_o;
    next_re_n  = re_n_o;
    next_oe_n  = dq_oe_n_o;
    next_dq    = dq_o;
    next_rdata = rdata_o;
    unique case (state)
      C_IDLE: begin
        if (start_i) begin
          next_state = C_LOW;
          next_cle   = (step_i.kind == K_CMD);
          next_ale   = (step_i.kind == K_ADDR);
          next_dq    = step_i.value;
          if (step_i.kind == K_DOUT) begin
            next_re_n = 1'b0;
            next_oe_n = 1'b1;
            next_cnt  = 8'(`RE_LOW_CYC - 1);
          end else begin
            next_we_n = 1'b0;
            next_oe_n = 1'b0;
            next_cnt  = 8'(`WE_LOW_CYC - 1);
          end
        end
      end
      C_LOW: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if (!re_n_o) begin
          if (dq_s2 == dq_s3) begin
            next_rdata = dq_s3;
            next_re_n  = 1'b1;
            next_state = C_HIGH;
            next_cnt   = 8'(`RE_HIGH_CYC - 1);
          end
        end else begin
          next_we_n  = 1'b1;
          next_state = C_HIGH;
          next_cnt   = 8'(`WE_HIGH_CYC - 1);
        end
      end
      C_HIGH: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else begin
          next_done  = 1'b1;
          next_cle   = 1'b0;
          next_ale   = 1'b0;
          next_oe_n  = 1'b1;
          next_state = C_IDLE;
        end
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state     <= C_IDLE;
      cnt       <= 8'h00;
      done_o    <= 1'b0;
      cle_o     <= 1'b0;
      ale_o     <= 1'b0;
      we_n_o    <= 1'b1;
      re_n_o    <= 1'b1;
      dq_oe_n_o <= 1'b1;
      dq_o      <= 8'h00;
      rdata_o   <= 8'h00;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      done_o    <= next_done;
      cle_o     <= next_cle;
      ale_o     <= next_ale;
      we_n_o    <= next_we_n;
      re_n_o    <= next_re_n;
      dq_oe_n_o <= next_oe_n;
      dq_o      <= next_dq;
      rdata_o   <= next_rdata;
    end
  end
endmodule

// ---- core/nand_cache_host.sv ----
// NAND cache read and program host: APB register slave plus command sequencer.
// Assumes one die on the pins; software orders one operation at a time.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "nand_seq_defs.svh"
module nand_cache_host (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // NAND pins.
  output logic             ce_n_o,
  output logic             wp_n_o,
  output logic             cle_o,
  output logic             ale_o,
  output logic             we_n_o,
  output logic             re_n_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_n_o,
  input  wire logic [7:0]  dq_i,
  input  wire logic        rb_n_i
);
  import nand_seq_pkg::*;

  seq_state_t state, next_state;
  mode_t      mode, next_mode;
  logic [4:0] op, next_op;
  logic [3:0] idx, next_idx;
  logic [7:0] wcnt, next_wcnt;
  logic       cyc_start, next_cyc_start;
  logic       cyc_done;
  logic [7:0] cyc_rdata;
  step_t      step;
  logic [31:0] addr_lo, next_addr_lo;
  logic [7:0] addr_hi, next_addr_hi, wdata, next_wdata, rdata, next_rdata;
  logic [7:0] status_byte, next_status_byte;
  logic       err, next_err, tp_active, next_tp_active, need_sel, next_need_sel;
  logic       have_prog, next_have_prog;
  logic [`ROW_BITS-1:0] read_row, next_read_row, prog_row, next_prog_row, addr_row;
  logic [31:0] next_prdata;
  logic       next_pready, next_pslverr, setup, access, wr, order_ok;
  logic       rb_s1, rb_s2, rb_s3, rb_level;

  // Ready/busy is a pin; it counts as changed once stages two and three agree.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rb_s1    <= 1'b0;
      rb_s2    <= 1'b0;
      rb_s3    <= 1'b0;
      rb_level <= 1'b0;
    end else begin
      rb_s1 <= rb_n_i;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (rb_s2 == rb_s3) begin
        rb_level <= rb_s3;
      end
    end
  end

  // Address byte i of the five-cycle address, plane bit forced where asked.
  function automatic logic [7:0] abyte(input logic [2:0] i, input logic force_pl,
                                       input logic pl);
    logic [7:0] b;
    b = (i == 3'd4) ? addr_hi : addr_lo[8*i[1:0] +: 8];
    if (force_pl && i == 3'(`PLANE_BYTE)) begin
      b[`PLANE_BIT] = pl;
    end
    return b;
  endfunction

  function automatic step_t mk(input step_kind_t k, input logic [7:0] v, input logic l,
                               input logic w);
    step_t s;
    s.kind      = k;
    s.value     = v;
    s.last      = l;
    s.wait_busy = w;
    return s;
  endfunction

  // Command-only step that ends the operation.
  function automatic step_t fin(input logic [7:0] v, input logic w);
    return mk(K_CMD, v, 1'b1, w);
  endfunction

  // Step list of every operation, indexed by idx.
  always_comb begin
    step = fin(`CMD_RESET, 1'b1);
    unique case (op)
      `OP_SEQ_CACHE:  step = fin(`CMD_CACHE_SEQ, 1'b1); // [R1] [R6]
      `OP_LAST_CACHE: step = fin(`CMD_CACHE_LAST, 1'b1); // [R11]
      `OP_READ_MODE:  step = fin(`CMD_READ, 1'b0); // [R24]
      `OP_PROG_GO:    step = fin(`CMD_PROG_GO, 1'b1); // [R18]
      `OP_PROG_CACHE: step = fin(`CMD_PROG_CACHE, 1'b1); // [R19]
      `OP_PROG_PLANE: step = fin(`CMD_PROG_PLANE, 1'b1); // [R22]
      `OP_DATA_IN:    step = mk(K_DIN, wdata, 1'b1, 1'b0);
      `OP_DATA_OUT:   step = mk(K_DOUT, 8'h00, 1'b1, 1'b0);
      `OP_RAND_CACHE, `OP_PLANE_SEL, `OP_PROG_SETUP: begin // [R8]
        if (idx == 4'd0) begin
          step = mk(K_CMD, (op == `OP_RAND_CACHE) ? `CMD_READ :
                           (op == `OP_PLANE_SEL) ? `CMD_PLANE_OUT : `CMD_PROG, 1'b0, 1'b0);
        end else if (idx <= 4'd5) begin
          step = mk(K_ADDR, abyte(3'(idx - 4'd1), 1'b0, 1'b0),
                    (op == `OP_PROG_SETUP) && idx == 4'd5, 1'b0);
        end else begin
          step = fin((op == `OP_RAND_CACHE) ? `CMD_CACHE_SEQ : `CMD_COL_GO,
                     op == `OP_RAND_CACHE);
        end
      end
      `OP_TP_READ: begin
        // One address register feeds both planes, so the columns always match. [R13]
        if (idx == 4'd0 || idx == 4'd6) begin
          step = mk(K_CMD, `CMD_READ, 1'b0, 1'b0); // [R12]
        end else if (idx <= 4'd5) begin
          step = mk(K_ADDR, abyte(3'(idx - 4'd1), 1'b1, 1'b0), 1'b0, 1'b0); // [R12]
        end else if (idx <= 4'd11) begin
          step = mk(K_ADDR, abyte(3'(idx - 4'd7), 1'b1, 1'b1), 1'b0, 1'b0); // [R12]
        end else begin
          step = fin(`CMD_READ_GO, 1'b1); // [R14]
        end
      end
      `OP_COL_OUT, `OP_COL_IN: begin // [R5]
        if (idx == 4'd0) begin
          step = mk(K_CMD, (op == `OP_COL_OUT) ? `CMD_COL_OUT : `CMD_COL_IN, 1'b0, 1'b0);
        end else if (idx <= 4'd2) begin
          step = mk(K_ADDR, abyte(3'(idx - 4'd1), 1'b0, 1'b0),
                    (op == `OP_COL_IN) && idx == 4'd2, 1'b0);
        end else begin
          step = fin(`CMD_COL_GO, 1'b0);
        end
      end
      `OP_STATUS, `OP_STATUS_ENH: begin // [R10]
        if (idx == 4'd0) begin
          step = mk(K_CMD, (op == `OP_STATUS) ? `CMD_STATUS : `CMD_STATUS_ENH, 1'b0, 1'b0);
        end else if (op == `OP_STATUS || idx == 4'd4) begin
          step = mk(K_DOUT, 8'h00, 1'b1, 1'b0);
        end else begin
          step = mk(K_ADDR, abyte(3'(idx + 4'd1), 1'b0, 1'b0), 1'b0, 1'b0);
        end
      end
      default: step = fin(`CMD_RESET, 1'b1);
    endcase
  end

  // Whether an operation may be sent in the die state this host has seen.
  function automatic logic op_valid(input logic [4:0] o, input logic rdy, input mode_t m);
    logic ok;
    ok = 1'b1;
    if (!rdy) begin
      ok = (o == `OP_STATUS) || (o == `OP_STATUS_ENH) || (o == `OP_RESET); // [R20] [R23]
    end else if (m == M_CACHE_READ) begin
      ok = (o <= `OP_DATA_OUT) && (o != `OP_PROG_SETUP) && (o != `OP_COL_IN) &&
           (o != `OP_DATA_IN) || (o == `OP_RESET); // [R2]
    end else if (m == M_CACHE_PROG) begin
      ok = (o == `OP_STATUS) || (o == `OP_STATUS_ENH) || (o >= `OP_PROG_SETUP &&
           o != `OP_DATA_OUT && o != `OP_PROG_PLANE); // [R21]
    end
    return ok && (o <= `OP_LAST); // [R25]
  endfunction

  assign addr_row = {addr_hi[0], addr_lo[31:16]};
  // Program order within one block must climb; a new block starts over. [R17]
  assign order_ok = !have_prog ||
                    (addr_row[`ROW_BITS-1:`PAGE_BITS] != prog_row[`ROW_BITS-1:`PAGE_BITS]) ||
                    (addr_row[`PAGE_BITS-1:0] > prog_row[`PAGE_BITS-1:0]);

  // APB decode, register file and sequencer next state.
  always_comb begin
    setup            = psel_i && !penable_i;
    access           = psel_i && penable_i && pready_o;
    wr               = access && pwrite_i && !pslverr_o;
    next_pready      = setup;
    next_pslverr     = 1'b0;
    next_prdata      = prdata_o;
    next_addr_lo     = addr_lo;
    next_addr_hi     = addr_hi;
    next_wdata       = wdata;
    next_rdata       = rdata;
    next_status_byte = status_byte;
    next_err         = err;
    next_state       = state;
    next_op          = op;
    next_idx         = idx;
    next_wcnt        = wcnt;
    next_cyc_start   = 1'b0;
    next_mode        = mode;
    next_tp_active   = tp_active;
    next_need_sel    = need_sel;
    next_read_row    = read_row;
    next_prog_row    = prog_row;
    next_have_prog   = have_prog;
    if (setup) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr_i[7:0])
        `REG_CTRL:    next_prdata = {27'h0000000, op};
        `REG_ADDR_LO: next_prdata = addr_lo;
        `REG_ADDR_HI: next_prdata = {24'h000000, addr_hi};
        `REG_WDATA:   next_prdata = {24'h000000, wdata};
        `REG_RDATA:   next_prdata = {24'h000000, rdata};
        `REG_STATUS:  next_prdata = {16'h0000, status_byte, 1'b0, need_sel, tp_active,
                                     mode, err, rb_level, state != S_IDLE};
        default:      next_pslverr = 1'b1;
      endcase
      if (paddr_i[31:8] != 24'h000000) begin
        next_pslverr = 1'b1;
      end
    end
    // Software writes; the refusal flag clears by writing one to its bit.
    if (wr && paddr_i[7:0] == `REG_ADDR_LO) next_addr_lo = pwdata_i;
    if (wr && paddr_i[7:0] == `REG_ADDR_HI) next_addr_hi = pwdata_i[7:0];
    if (wr && paddr_i[7:0] == `REG_WDATA) next_wdata = pwdata_i[7:0];
    if (wr && paddr_i[7:0] == `REG_STATUS && pwdata_i[`ERR_BIT]) next_err = 1'b0;
    // A new order is sent only when legal for the state the die is in.
    if (wr && paddr_i[7:0] == `REG_CTRL) begin
      if (state != S_IDLE || !op_valid(pwdata_i[4:0], rb_level, mode) ||
          (pwdata_i[4:0] == `OP_STATUS_ENH && tp_active) || // [R16]
          (pwdata_i[4:0] == `OP_DATA_OUT && need_sel) || // [R15]
          (pwdata_i[4:0] == `OP_SEQ_CACHE && (&read_row)) || // [R7]
          (pwdata_i[4:0] == `OP_PROG_SETUP && !order_ok)) begin
        next_err = 1'b1;
      end else begin
        next_op        = pwdata_i[4:0];
        next_idx       = 4'd0;
        next_state     = S_RUN;
        next_cyc_start = 1'b1;
        unique case (pwdata_i[4:0])
          `OP_SEQ_CACHE: begin
            next_mode     = M_CACHE_READ; // [R3] [R4]
            next_read_row = read_row + `ROW_BITS'(1); // [R6]
          end
          `OP_RAND_CACHE: begin
            next_mode     = M_CACHE_READ; // [R3] [R4] [R9]
            next_read_row = addr_row;
          end
          `OP_LAST_CACHE, `OP_PROG_GO, `OP_RESET: begin
            next_mode      = M_IDLE; // [R11] [R18]
            next_tp_active = 1'b0;
            next_need_sel  = 1'b0;
          end
          `OP_TP_READ: begin
            next_tp_active = 1'b1; // [R14]
            next_read_row  = addr_row;
          end
          `OP_PLANE_SEL:  next_need_sel = 1'b0; // [R15]
          `OP_PROG_CACHE: next_mode = M_CACHE_PROG; // [R19]
          `OP_PROG_SETUP: begin
            next_prog_row  = addr_row; // [R17]
            next_have_prog = 1'b1;
            next_tp_active = 1'b0;
          end
          default: ;
        endcase
      end
    end
    // Sequencer: one pin cycle per step, then a settle wait for busy to show where the last step asks for it.
    unique case (state)
      S_IDLE: ;
      S_RUN: begin
        if (cyc_done) begin
          if (step.kind == K_DOUT) begin
            if (op == `OP_DATA_OUT) begin
              next_rdata = cyc_rdata;
            end else begin
              next_status_byte = cyc_rdata;
              if (cyc_rdata[`ST_RDY_BIT] && cyc_rdata[`ST_ARRAY_READY_BIT]) begin
                next_mode = M_IDLE; // [R18]
              end
              if (tp_active && op == `OP_STATUS) begin
                next_need_sel = 1'b1; // [R15]
              end
            end
          end
          if (!step.last) begin
            next_idx       = idx + 4'd1;
            next_cyc_start = 1'b1;
          end else if (step.wait_busy) begin
            next_state = S_WAIT;
            next_wcnt  = 8'(`WB_CYC - 1);
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_WAIT: begin
        // Covers the busy-line delay plus its synchroniser, so busy is seen before idle.
        if (wcnt == 8'h00) begin
          next_state = S_IDLE;
        end else begin
          next_wcnt = wcnt - 8'h01;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Registers only.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o    <= 32'h0000_0000;
      pready_o    <= 1'b0;
      pslverr_o   <= 1'b0;
      ce_n_o      <= 1'b1;
      wp_n_o      <= 1'b0;
      addr_lo     <= 32'h0000_0000;
      addr_hi     <= 8'h00;
      wdata       <= 8'h00;
      rdata       <= 8'h00;
      status_byte <= 8'h00;
      err         <= 1'b0;
      state       <= S_IDLE;
      op          <= `OP_RESET;
      idx         <= 4'd0;
      wcnt        <= 8'h00;
      cyc_start   <= 1'b0;
      mode        <= M_IDLE;
      tp_active   <= 1'b0;
      need_sel    <= 1'b0;
      read_row    <= '0;
      prog_row    <= '0;
      have_prog   <= 1'b0;
    end else begin
      prdata_o    <= next_prdata;
      pready_o    <= next_pready;
      pslverr_o   <= next_pslverr;
      ce_n_o      <= 1'b0;
      wp_n_o      <= 1'b1;
      addr_lo     <= next_addr_lo;
      addr_hi     <= next_addr_hi;
      wdata       <= next_wdata;
      rdata       <= next_rdata;
      status_byte <= next_status_byte;
      err         <= next_err;
      state       <= next_state;
      op          <= next_op;
      idx         <= next_idx;
      wcnt        <= next_wcnt;
      cyc_start   <= next_cyc_start;
      mode        <= next_mode;
      tp_active   <= next_tp_active;
      need_sel    <= next_need_sel;
      read_row    <= next_read_row;
      prog_row    <= next_prog_row;
      have_prog   <= next_have_prog;
    end
  end

  // Pin-cycle engine.
  nand_bus_cycle u_cycle (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .start_i   (cyc_start),
    .step_i    (step),
    .done_o    (cyc_done),
    .rdata_o   (cyc_rdata),
    .cle_o     (cle_o),
    .ale_o     (ale_o),
    .we_n_o    (we_n_o),
    .re_n_o    (re_n_o),
    .dq_o      (dq_o),
    .dq_oe_n_o (dq_oe_n_o),
    .dq_i      (dq_i)
  );
endmodule

// ---- testbench/nand_cache_host_checker.sv ----
// Checker of APB answers and NAND pin strobes at the host's ports.
// Assumes a bind into nand_cache_host.
`timescale 1ns/1ps
module nand_cache_host_checker (
  input wire logic       ref_clk_i, reset_n_i, psel_i, penable_i, pready_o, pslverr_o,
  input wire logic       cle_o, ale_o, we_n_o, re_n_o, dq_oe_n_o, rb_n_i,
  input wire logic [7:0] dq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // A write strobe is low four cycles, then high.
  sequence s_we; !we_n_o [*4] ##1 we_n_o; endsequence
  property p_ans; psel_i && !penable_i |=> pready_o; endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_once; pready_o |=> !pready_o; endproperty
  a_once: assert property (p_once) else $error("long answer");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_we; $fell(we_n_o) |-> s_we; endproperty
  a_we: assert property (p_we) else $error("bad write strobe");
  property p_re; $fell(re_n_o) |-> !re_n_o [*7]; endproperty
  a_re: assert property (p_re) else $error("short read strobe");
  // Latches capture on the rising strobe, so the cycle value must not move.
  property p_hold; $fell(we_n_o) |=> $stable({cle_o, ale_o, dq_o}) [*5]; endproperty
  a_hold: assert property (p_hold) else $error("cycle value moved");
  property p_oe; !re_n_o |-> dq_oe_n_o; endproperty
  a_oe: assert property (p_oe) else $error("bus contention");
  property p_busy; $fell(we_n_o) && cle_o && !rb_n_i |-> dq_o inside {8'h70, 8'h78, 8'hFF};
  endproperty
  a_busy: assert property (p_busy) else $error("command while busy");
endmodule
bind nand_cache_host nand_cache_host_checker nand_cache_host_checker_inst (.ref_clk_i,
  .reset_n_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .cle_o, .ale_o, .we_n_o, .re_n_o,
  .dq_oe_n_o, .rb_n_i, .dq_o);

// ---- testbench/nand_die_model.sv ----
// Behavioural NAND die on the far side of the host's pins.
// Assumes the host drives dq only while its enable is low.
`timescale 1ns/1ps
module nand_die_model (
  input  wire logic       clk_i, rst_n_i, cle_i, ale_i, we_n_i, re_n_i, oe_n_i,
  input  wire logic [7:0] dq_h_i,
  output logic      [7:0] dq_o,
  output logic            rb_n_o
);
  logic [7:0] col, acol, last;
  logic       we_q, re_q, array_ready, stat;
  int         busy;
  wire        up = we_n_i && !we_q;
  // A released bus shows the inverse of its last level, so no stale byte passes.
  assign dq_o = !oe_n_i ? dq_h_i : re_n_i ? ~last
              : stat ? {1'b0, rb_n_o, array_ready & rb_n_o, 5'h00} : col;
  assign rb_n_o = busy == 0;
  // Confirm codes start a busy time; 31h and 15h leave the array busy after it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {col, acol, last, stat, busy} <= '0;
      {we_q, re_q, array_ready} <= 3'b111;
    end else begin
      {we_q, re_q, last} <= {we_n_i, re_n_i, dq_o};
      if (busy > 0)
        busy <= busy - 1;
      if (busy == 1 || re_n_i && !re_q && !stat)
        col <= busy == 1 ? 8'h00 : col + 8'h01;
      if (up && ale_i)
        acol <= dq_h_i;
      if (up && cle_i) begin
        stat <= dq_h_i inside {8'h70, 8'h78};
        if (dq_h_i == 8'hE0)
          col <= acol;
        if (dq_h_i inside {8'h31, 8'h3F, 8'h30, 8'h10, 8'h15, 8'h11}) begin
          busy <= dq_h_i[0] ? 120 : 20;
          array_ready <= !(dq_h_i inside {8'h31, 8'h15});
        end
      end
    end
  end
endmodule

// ---- testbench/nand_cache_host_tb.sv ----
// Bench: APB orders into the host, a behavioural die on its pins.
// Assumes one-cycle APB answers and busy shown in STATUS bit 0.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module nand_cache_host_tb;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic pready_o, pslverr_o, se, rb_n_i, cle_o, ale_o, we_n_o, re_n_o, dq_oe_n_o;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rd;
  logic [7:0]  dq_o, dq_i;
  int          errors = 0, checked = 0, cyc = 0;
  // Row: op, expected STATUS[5:2], expected byte after a data-out op.
  logic [19:0] t [30] = '{20'h00200, 20'h0C200, 20'h0C201, 20'h04200, 20'h0C222, 20'h01200,
    20'h0C200, 20'h09300, 20'h02000, 20'h0C000, 20'h06000, 20'h08000, 20'h0C001, 20'h09000,
    20'h0B000, 20'h0E400, 20'h00500, 20'h09500, 20'h06400, 20'h0D000, 20'h0A000, 20'h0F000,
    20'h10000, 20'h11100, 20'h03800, 20'h06800, 20'h0C901, 20'h05800, 20'h0C800, 20'h07900};
  nand_cache_host nand_cache_host_inst (.ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ce_n_o(), .wp_n_o(), .cle_o,
    .ale_o, .we_n_o, .re_n_o, .dq_o, .dq_oe_n_o, .dq_i, .rb_n_i);
  nand_die_model nand_die_model_inst (.clk_i(ref_clk_i), .rst_n_i(reset_n_i), .cle_i(cle_o),
    .ale_i(ale_o), .we_n_i(we_n_o), .re_n_i(re_n_o), .oe_n_i(dq_oe_n_o), .dq_h_i(dq_o),
    .dq_o(dq_i), .rb_n_o(rb_n_i));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  // A request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [31:0] a, d);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge ref_clk_i) penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    {rd, se, psel_i, penable_i} <= {prdata_o, pslverr_o, 2'b00};
    @(posedge ref_clk_i);
  endtask
  // Polling until idle with the die ready still leaves some orders refused as illegal.
  task automatic op(input logic [4:0] n);
    apb(1'b1, 32'h0, {27'h0, n});
    for (int i = 0; i < 2 || rd[1:0] !== 2'b10; i++)
      apb(1'b0, 32'h14, 32'h0);
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // The ceiling sits well above the longest expected run.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, 32'h100, 32'h0);
    `CHK("pslverr", 1'b1, se)
    apb(1'b1, 32'h4, 32'h0001_2200);
    foreach (t[k]) begin
      op(t[k][16:12]);
      `CHK("status", t[k][11:8], rd[5:2])
      apb(1'b1, 32'h14, 32'h4);
      if (t[k][19:12] == 8'h0C)
        apb(1'b0, 32'h10, 32'h0);
      if (t[k][19:12] == 8'h0C)
        `CHK("rdata", t[k][7:0], rd[7:0])
    end
    summarize();
  end
endmodule
